/* include/sjt_defs.svh */
// constants for the sram test access port
`ifndef SJT_DEFS_SVH
`define SJT_DEFS_SVH
`define SJT_IR_W        3
`define SJT_ID_W        32
`define SJT_IR_CAPTURE  3'h1
`define SJT_INS_EXTEST  3'h0
`define SJT_INS_IDCODE  3'h1
`define SJT_INS_SAMPLE  3'h2
`define SJT_INS_BYPASS  3'h7
`define SJT_RST_EDGES   5
`endif

/* include/sjt_pkg.sv */
// types for the sram test access port
package sjt_pkg;
  typedef enum logic [3:0] {
    SJT_TLR  = 4'h0,
    SJT_RTI  = 4'h1,
    SJT_SDRS = 4'h2,
    SJT_CDR  = 4'h3,
    SJT_SDR  = 4'h4,
    SJT_E1DR = 4'h5,
    SJT_PDR  = 4'h6,
    SJT_E2DR = 4'h7,
    SJT_UDR  = 4'h8,
    SJT_SIRS = 4'h9,
    SJT_CIR  = 4'ha,
    SJT_SIR  = 4'hb,
    SJT_E1IR = 4'hc,
    SJT_PIR  = 4'hd,
    SJT_E2IR = 4'he,
    SJT_UIR  = 4'hf
  } sjt_state_e;
  typedef logic [2:0] sjt_ins_t;
endpackage

/* hdl/sjt_sync.sv */
// two-flop synchroniser for pin inputs
`default_nettype none
module sjt_sync (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_reg;
  // resets to one: an idle pin reads as a pulled-up level
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= 1'b1;
      o_q      <= 1'b1;
    end else if (i_ce) begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* hdl/sjt_fsm.sv */
// tap controller state stepping
`default_nettype none
module sjt_fsm
  import sjt_pkg::*;
(
  input  wire logic          i_tms,
  input  wire sjt_pkg::sjt_state_e i_cur,
  output sjt_pkg::sjt_state_e      o_next
);
  always_comb begin
    case (i_cur)
      SJT_TLR:  o_next = i_tms ? SJT_TLR  : SJT_RTI;
      SJT_RTI:  o_next = i_tms ? SJT_SDRS : SJT_RTI;
      SJT_SDRS: o_next = i_tms ? SJT_SIRS : SJT_CDR;
      SJT_CDR:  o_next = i_tms ? SJT_E1DR : SJT_SDR;
      SJT_SDR:  o_next = i_tms ? SJT_E1DR : SJT_SDR;
      SJT_E1DR: o_next = i_tms ? SJT_UDR  : SJT_PDR;
      SJT_PDR:  o_next = i_tms ? SJT_E2DR : SJT_PDR;
      SJT_E2DR: o_next = i_tms ? SJT_UDR  : SJT_SDR;
      SJT_UDR:  o_next = i_tms ? SJT_SDRS : SJT_RTI;
      SJT_SIRS: o_next = i_tms ? SJT_TLR  : SJT_CIR;
      SJT_CIR:  o_next = i_tms ? SJT_E1IR : SJT_SIR;
      SJT_SIR:  o_next = i_tms ? SJT_E1IR : SJT_SIR;
      SJT_E1IR: o_next = i_tms ? SJT_UIR  : SJT_PIR;
      SJT_PIR:  o_next = i_tms ? SJT_E2IR : SJT_PIR;
      SJT_E2IR: o_next = i_tms ? SJT_UIR  : SJT_SIR;
      SJT_UIR:  o_next = i_tms ? SJT_SDRS : SJT_RTI;
      default:  o_next = SJT_TLR;
    endcase
  end
endmodule
`default_nettype wire

/* hdl/sjt_tap.sv */
// boundary-scan test access port of the sram
`include "sjt_defs.svh"
`default_nettype none
// How it works
// - standard sixteen-state tap controller implemented
// - inputs on test clock rise, tdo on fall, status outputs each clk
// - sampled tms alone steps the controller
// - floating tms reads as one
// - floating tdi reads as one
// - state and instruction pick the serial path
// - tdo driven only while shifting, path's end
// - tdo changes only on test clock fall
// - no test reset pin; tms or power-up
// - five tms-high rises reach test-logic-reset
// - controller resets itself at power-up
// - port stays idle until test clock toggles
// - three-bit instruction, idcode preloaded on reset
// - capture-ir loads 01 into low bits
// - one-bit bypass path under bypass
// - 32-bit id captured, shifted lsb first
module sjt_tap
  import sjt_pkg::*;
#(
  parameter logic [31:0] ID_CODE = 32'h0000_0001 // arbitrary value
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  input  wire logic i_tck,
  input  wire logic i_tms,
  input  wire logic i_tms_oe,
  input  wire logic i_tdi,
  input  wire logic i_tdi_oe,
  output logic      o_tdo,
  output logic      o_tdo_oe,
  output logic      o_tap_reset,
  output logic [2:0] o_ins
);
  logic       tck_s;
  logic       tms_s;
  logic       tdi_s;
  logic       tck_d_reg;
  logic       rise;
  logic       fall;
  logic       tms_raw_s;
  logic       tms_oe_s;
  logic       tdi_raw_s;
  logic       tdi_oe_s;
  sjt_state_e state_reg;
  sjt_state_e state_next;
  sjt_ins_t   ir_sh_reg;
  sjt_ins_t   ir_reg;
  logic       byp_reg;
  logic [31:0] id_reg;
  logic       path_bit;
  logic       shifting;

  function automatic logic is_id(input sjt_ins_t ins);
    return ins == `SJT_INS_IDCODE;
  endfunction

  sjt_sync u_sync_tck (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_d      (i_tck),
    .o_q      (tck_s)
  );
  // value and enable cross apart; both settle long before a rise
  sjt_sync u_sync_tms (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_d      (i_tms),
    .o_q      (tms_raw_s)
  );
  sjt_sync u_sync_tms_oe (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_d      (i_tms_oe),
    .o_q      (tms_oe_s)
  );
  sjt_sync u_sync_tdi (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_d      (i_tdi),
    .o_q      (tdi_raw_s)
  );
  sjt_sync u_sync_tdi_oe (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_d      (i_tdi_oe),
    .o_q      (tdi_oe_s)
  );

  // a pin whose driver is absent acts as pulled up
  assign tms_s = tms_oe_s ? tms_raw_s : 1'b1;
  assign tdi_s = tdi_oe_s ? tdi_raw_s : 1'b1;

  // edge finder; tck resets high so a parked clock gives no edge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tck_d_reg <= 1'b1;
    end else if (i_ce) begin
      tck_d_reg <= tck_s;
    end
  end
  assign rise = tck_s & ~tck_d_reg;
  assign fall = ~tck_s & tck_d_reg;

  sjt_fsm u_fsm (
    .i_tms  (tms_s),
    .i_cur  (state_reg),
    .o_next (state_next)
  );

  // power-up reset is the only asynchronous path; no test reset pin
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= SJT_TLR;
    end else if (i_ce && rise) begin
      state_reg <= state_next;
    end
  end

  // instruction shifter and active instruction
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ir_sh_reg <= `SJT_INS_IDCODE;
      ir_reg    <= `SJT_INS_IDCODE;
    end else if (i_ce && rise) begin
      if (state_next == SJT_TLR) begin
        ir_reg <= `SJT_INS_IDCODE;
      end
      case (state_reg)
        SJT_CIR: begin
          ir_sh_reg <= `SJT_IR_CAPTURE;
        end
        SJT_SIR: begin
          ir_sh_reg <= {tdi_s, ir_sh_reg[2:1]};
        end
        SJT_UIR: begin
          ir_reg <= ir_sh_reg;
        end
        default: begin
        end
      endcase
    end
  end

  // data registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      byp_reg <= 1'b0;
      id_reg  <= 32'h0000_0000;
    end else if (i_ce && rise) begin
      if (state_reg == SJT_CDR) begin
        byp_reg <= 1'b0;
        if (is_id(ir_reg)) begin
          id_reg <= ID_CODE;
        end
      end else if (state_reg == SJT_SDR) begin
        byp_reg <= tdi_s;
        if (is_id(ir_reg)) begin
          id_reg <= {tdi_s, id_reg[31:1]};
        end
      end
    end
  end

  // path end: shift-ir uses the instruction shifter; otherwise idcode uses id, anything else unimplemented acts as bypass
  always_comb begin
    if (state_reg == SJT_SIR) begin
      path_bit = ir_sh_reg[0];
    end else if (is_id(ir_reg)) begin
      path_bit = id_reg[0];
    end else begin
      path_bit = byp_reg;
    end
  end
  assign shifting = (state_reg == SJT_SDR) || (state_reg == SJT_SIR);

  // output launched on the falling edge after the shift state is entered
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (i_ce && fall) begin
      o_tdo    <= path_bit;
      o_tdo_oe <= shifting;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tap_reset <= 1'b1;
      o_ins       <= `SJT_INS_IDCODE;
    end else if (i_ce) begin
      o_tap_reset <= (state_reg == SJT_TLR);
      o_ins       <= ir_reg;
    end
  end

  // five rises with tms high from anywhere end in reset
  logic [2:0] hi_cnt_reg;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hi_cnt_reg <= 3'h0;
    end else if (i_ce && rise) begin
      if (!tms_s) begin
        hi_cnt_reg <= 3'h0;
      end else if (hi_cnt_reg != 3'h7) begin
        hi_cnt_reg <= hi_cnt_reg + 3'h1;
      end
    end
  end

  AST_FIVE_HIGH_RESET: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    hi_cnt_reg >= 3'(`SJT_RST_EDGES) |-> state_reg == SJT_TLR)
    else $error("tap not in reset after five tms-high rises");

  AST_STEP_ONLY_ON_RISE: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !(i_ce && rise) |=> $stable(state_reg))
    else $error("state moved without a test clock rise");

  AST_TDO_ONLY_ON_FALL: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !$past(i_ce && fall) |-> $stable(o_tdo) && $stable(o_tdo_oe))
    else $error("tdo changed without a test clock fall");

  AST_TDO_OFF_IDLE: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && fall && !shifting) |=> !o_tdo_oe)
    else $error("tdo enabled outside shift states");

  AST_TDO_ON_SHIFT: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && fall && shifting) |=> o_tdo_oe && o_tdo == $past(path_bit))
    else $error("tdo not driven from path end while shifting");

  AST_CAPTURE_IR: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && rise && state_reg == SJT_CIR) |=> ir_sh_reg[1:0] == 2'h1)
    else $error("capture-ir did not load 01");

  AST_TLR_IDCODE: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && rise && state_reg == SJT_TLR) |=> ir_reg == `SJT_INS_IDCODE)
    else $error("idcode not preloaded in reset state");

  AST_ID_CAPTURE: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && rise && state_reg == SJT_CDR && ir_reg == `SJT_INS_IDCODE)
    |=> id_reg == ID_CODE)
    else $error("id register not captured");

  AST_BYPASS_SHIFT: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && rise && state_reg == SJT_SDR) |=> byp_reg == $past(tdi_s))
    else $error("bypass bit did not take tdi");

  AST_IDLE_TCK: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    $past(i_ce) && $stable(tck_s) |-> !rise && !fall)
    else $error("edge seen on a parked test clock");

  COV_IR_UPDATE: cover property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && rise && state_reg == SJT_UIR);
  COV_ID_SHIFT: cover property (
    @(posedge i_clk) disable iff (!i_resetn)
    o_tdo_oe && ir_reg == `SJT_INS_IDCODE);
  COV_BYPASS: cover property (
    @(posedge i_clk) disable iff (!i_resetn)
    o_tdo_oe && ir_reg == `SJT_INS_BYPASS);
  COV_FIVE_RESET: cover property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && rise && tms_s && hi_cnt_reg == 3'h4);
  COV_TMS_FLOAT: cover property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && rise && !tms_oe_s);

  AST_TLR_ENTRY_IDCODE: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && rise && state_next == SJT_TLR) |=> ir_reg == `SJT_INS_IDCODE)
    else $error("idcode not loaded on entering reset state");

  AST_IR_UPDATE: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && rise && state_reg == SJT_UIR) |=> ir_reg == $past(ir_sh_reg))
    else $error("instruction not updated from shifter");

  AST_STATUS_LAG: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce |=> o_tap_reset == $past(state_reg == SJT_TLR)
    && o_ins == $past(ir_reg))
    else $error("status outputs do not follow the controller");
endmodule
`default_nettype wire

/* sim/sjt_ctl_model.sv */
// behavioural boundary-scan test controller driving the tap pins
`default_nettype none
module sjt_ctl_model (
  input  wire logic i_clk,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tms_oe,
  output logic      o_tdi,
  output logic      o_tdi_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rel_tms;
  logic rel_tdi;
  initial begin
    rel_tms = 1'b0;
    rel_tdi = 1'b0;
    o_tck = 1'b1; // rests high between frames
    o_tms = 1'b1;
    o_tms_oe = 1'b1;
    o_tdi = 1'b1;
    o_tdi_oe = 1'b1;
  end
  // one tck period of 8 clk: drive on fall, sample tdo before rise
  // a released pin carries 0 on purpose: only the enable may count
  task automatic step(input logic tms, input logic tdi,
                      output logic tdo, output logic oe);
    o_tck <= 1'b0;
    o_tms <= rel_tms ? 1'b0 : tms;
    o_tms_oe <= !rel_tms;
    o_tdi <= rel_tdi ? 1'b0 : tdi;
    o_tdi_oe <= !rel_tdi;
    repeat (4) @(posedge i_clk);
    #1;
    tdo = i_tdo;
    oe = i_tdo_oe;
    @(posedge i_clk);
    o_tck <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the sram test access port
`include "sjt_defs.svh"
`default_nettype none
module tb;
  import sjt_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ID  = 32'h5a5a_3c3d; // arbitrary value
  localparam logic [31:0] PAT = 32'hc3a5_0f96;
  logic       clk;
  logic       resetn;
  logic       tck, tms, tms_oe, tdi, tdi_oe, tdo, tdo_oe, tap_reset;
  logic [2:0] ins;
  logic       so, se, tck_q;
  logic [1:0] tdo_q;
  int         err_total, samples_checked, since_fall;
  sjt_tap #(.ID_CODE(ID)) i_dut (
    .i_clk(clk), .i_resetn(resetn), .i_ce(1'b1), .i_tck(tck),
    .i_tms(tms), .i_tms_oe(tms_oe), .i_tdi(tdi), .i_tdi_oe(tdi_oe),
    .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_tap_reset(tap_reset), .o_ins(ins));
  sjt_ctl_model i_ctl (
    .i_clk(clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck),
    .o_tms(tms), .o_tms_oe(tms_oe), .o_tdi(tdi), .o_tdi_oe(tdi_oe));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // tdo may only move in the third clk after a tck pin fall
  initial begin
    tdo_q = 2'b00;
    tck_q = 1'b1;
    since_fall = 8;
  end
  always @(negedge clk) begin
    since_fall = (tck_q === 1'b1 && tck === 1'b0) ? 0 : since_fall + 1;
    if (since_fall != 3) chk("tdo_steady", tdo_q, {tdo_oe, tdo});
    tdo_q = {tdo_oe, tdo};
    tck_q = tck;
  end
  task automatic walk(input logic [7:0] seq, input int n);
    for (int i = 0; i < n; i++) i_ctl.step(seq[i], 1'b0, so, se);
  endtask
  task automatic t_power();
    repeat (20) @(posedge clk);
    chk("tap_reset", 1, tap_reset);
    chk("ins", `SJT_INS_IDCODE, ins);
    chk("tdo_oe", 0, tdo_oe);
    walk(8'h00, 1);
  endtask
  task automatic t_ir(input sjt_ins_t code);
    logic [2:0] cap;
    cap = `SJT_IR_CAPTURE;
    walk(8'b0011, 4);
    for (int i = 0; i < 3; i++) begin
      i_ctl.step(i == 2, code[i], so, se);
      chk("ir_out", cap[i], so);
      chk("ir_oe", 1, se);
    end
    walk(8'b01, 2);
    repeat (2) @(posedge clk);
    chk("ins", code, ins);
  endtask
  // bypass shows its captured 0 then tdi one period late
  task automatic t_dr(input sjt_ins_t code, input logic rel);
    logic [31:0] got;
    logic [31:0] eff;
    walk(8'b001, 3);
    i_ctl.rel_tdi = rel;
    for (int i = 0; i < 32; i++) begin
      i_ctl.step(i == 31, PAT[i], so, se);
      got[i] = so;
      chk("dr_oe", 1, se);
    end
    i_ctl.rel_tdi = 1'b0;
    eff = rel ? 32'hffff_ffff : PAT;
    chk("dr_out", (code == `SJT_INS_IDCODE) ? ID : {eff[30:0], 1'b0},
        got);
    walk(8'b01, 2);
    chk("dr_oe_off", 0, se);
  endtask
  task automatic t_reset5(input logic rel);
    walk(8'b0011, 4);
    i_ctl.rel_tms = rel;
    walk(8'hff, 4);
    chk("tap_reset", 0, tap_reset);
    walk(8'hff, 1);
    repeat (2) @(posedge clk);
    chk("tap_reset", 1, tap_reset);
    chk("ins", `SJT_INS_IDCODE, ins);
    i_ctl.rel_tms = 1'b0;
    walk(8'h00, 1);
  endtask
  initial begin
    sjt_ins_t codes [4];
    codes = '{`SJT_INS_EXTEST, `SJT_INS_SAMPLE, `SJT_INS_BYPASS, 3'h5};
    err_total = 0;
    samples_checked = 0;
    resetn = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_power();
    t_dr(`SJT_INS_IDCODE, 1'b0);
    foreach (codes[k]) begin
      t_ir(codes[k]);
      t_dr(codes[k], codes[k] == `SJT_INS_SAMPLE);
    end
    t_ir(`SJT_INS_IDCODE);
    t_dr(`SJT_INS_IDCODE, 1'b0);
    t_ir(`SJT_INS_BYPASS);
    t_reset5(1'b0);
    t_ir(`SJT_INS_EXTEST);
    t_reset5(1'b1);
    t_dr(`SJT_INS_IDCODE, 1'b0);
    close_out();
  end
  // about 350 tck periods of 64 ns are planned; allow several times that
  initial begin
    #150us;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
